/* dtd_transfer_unit.v */
// Decode and execution of register and memory data-transfer instructions
//
// How it works
// - Register numbers come from 4-bit instruction fields, code 0 to 15 naming register 0 to 15.
// - Each transfer is accepted in one cycle when no data access is pending and no fetch holds the bus.
// - A data access that meets an instruction fetch on the bus holds the instruction back.
// - An instruction reading the register a pending load writes is stalled until it lands.
// - No transfer changes the condition flag.
// - Top nibble 1110 writes the sign-extended 8-bit literal into the register in bits 11:8.
// - Top nibble 1101 loads a longword from program counter plus offset times 4.
// - Byte and word loads sign-extend the fetched data; longword loads keep it as fetched.
// - Pre-decrement stores lower the address register by 1, 2 or 4 and store there.
// - Post-increment loads read at the source register, then raise it by 1, 2 or 4.
// - Register-zero byte and word stores address base plus offset scaled by 1 or 2.
// - Top nibble 0001 stores the source at base plus 4-bit offset times 4.
// - Top nibble 0101 loads the destination from source base plus 4-bit offset times 4.
// - Indexed byte and word stores write the source at register zero plus the destination.
`timescale 1ns/1ps
`include "dtd_defs.vh"

module dtd_transfer_unit (
  input wire ref_clk,
  input wire sys_rst,
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire [31:0] program_counter,
  output wire instr_ready,
  input wire fetch_busy,
  output reg mem_req,
  output reg mem_we,
  output reg [1:0] mem_size,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  output reg cpu_flags_we,
  output reg illegal_op,
  input wire [3:0] peek_sel,
  output reg [31:0] peek_data
);

  // Instruction fields
  wire [3:0] op_top = instr_word[15:12];
  wire [3:0] dest_field = instr_word[11:8];
  wire [3:0] source_field = instr_word[7:4];
  wire [3:0] op_low = instr_word[3:0];
  wire [7:0] op_byte8 = instr_word[7:0];

  reg [31:0] rf [0:15];
  wire [31:0] dest_reg = rf[dest_field];
  wire [31:0] source_reg = rf[source_field];
  wire [31:0] index_reg_zero = rf[`DTD_REG_ZERO];

  // Decoded view of the presented instruction
  reg dec_mem;
  reg dec_load;
  reg [1:0] dec_size;
  reg [31:0] dec_addr;
  reg [31:0] dec_wdata;
  reg [3:0] dec_ld_dest;
  reg dec_rf_we;
  reg [3:0] dec_rf_sel;
  reg [31:0] dec_rf_data;
  reg uses_dest;
  reg uses_source;
  reg uses_zero;
  reg dec_bad;
  reg [31:0] step;

  // Pending memory access
  reg pend_load;
  reg [3:0] pend_dest;

  wire [31:0] imm_ext;
  wire [31:0] load_ext;

  // Literal sign extension shares the byte path of the extender
  dtd_load_extend u_imm_ext (
    .size(`DTD_SZ_BYTE),
    .raw({24'h000000, op_byte8}),
    .ext(imm_ext)
  );

  dtd_load_extend u_load_ext (
    .size(mem_size),
    .raw(mem_rdata),
    .ext(load_ext)
  );

  // Decode; displacements are unsigned and scaled by access size
  always @*
  begin
    dec_mem = 1'b0;
    dec_load = 1'b0;
    dec_size = `DTD_SZ_LONG;
    dec_addr = 32'h00000000;
    dec_wdata = source_reg;
    dec_ld_dest = dest_field;
    dec_rf_we = 1'b0;
    dec_rf_sel = dest_field;
    dec_rf_data = source_reg;
    uses_dest = 1'b0;
    uses_source = 1'b0;
    uses_zero = 1'b0;
    dec_bad = 1'b0;
    step = 32'h00000001 << op_low[1:0];
    case (op_top)
      `DTD_TOP_IMM:
      begin
        dec_rf_we = 1'b1;
        dec_rf_data = imm_ext;
      end
      `DTD_TOP_PC_LDW:
      begin
        dec_mem = 1'b1;
        dec_load = 1'b1;
        dec_size = `DTD_SZ_WORD;
        dec_addr = program_counter + {23'h000000, op_byte8, 1'b0};
      end
      `DTD_TOP_PC_LDL:
      begin
        dec_mem = 1'b1;
        dec_load = 1'b1;
        dec_addr = program_counter + {22'h000000, op_byte8, 2'h0};
      end
      `DTD_TOP_DISP_STL:
      begin
        dec_mem = 1'b1;
        uses_dest = 1'b1;
        uses_source = 1'b1;
        dec_addr = dest_reg + {26'h0000000, op_low, 2'h0};
      end
      `DTD_TOP_DISP_LDL:
      begin
        dec_mem = 1'b1;
        dec_load = 1'b1;
        uses_source = 1'b1;
        dec_addr = source_reg + {26'h0000000, op_low, 2'h0};
      end
      `DTD_TOP_DISP_R0:
      begin
        dec_mem = 1'b1;
        uses_source = 1'b1;
        dec_wdata = index_reg_zero;
        dec_ld_dest = `DTD_REG_ZERO;
        dec_size = dest_field[0] ? `DTD_SZ_WORD : `DTD_SZ_BYTE;
        dec_addr = dest_field[0] ? source_reg + {27'h0000000, op_low, 1'b0}
                                 : source_reg + {28'h0000000, op_low};
        case (dest_field)
          `DTD_SUB_ST_B, `DTD_SUB_ST_W: uses_zero = 1'b1;
          `DTD_SUB_LD_B, `DTD_SUB_LD_W: dec_load = 1'b1;
          default:
          begin
            dec_mem = 1'b0;
            dec_bad = 1'b1;
          end
        endcase
      end
      `DTD_TOP_IDX_STORE:
      begin
        dec_size = op_low[1:0];
        uses_dest = 1'b1;
        uses_source = 1'b1;
        uses_zero = 1'b1;
        dec_addr = index_reg_zero + dest_reg;
        if (op_low == `DTD_LOW_AUTO_B || op_low == `DTD_LOW_AUTO_W)
          dec_mem = 1'b1;
        else
          dec_bad = 1'b1;
      end
      `DTD_TOP_REG_STORE:
      begin
        dec_size = op_low[1:0];
        uses_dest = 1'b1;
        uses_source = 1'b1;
        if (op_low <= `DTD_LOW_PLAIN_L)
        begin
          dec_mem = 1'b1;
          dec_addr = dest_reg;
        end
        else if (op_low >= `DTD_LOW_AUTO_B && op_low <= `DTD_LOW_AUTO_L)
        begin
          dec_mem = 1'b1;
          dec_addr = dest_reg - step;
          dec_rf_we = 1'b1;
          dec_rf_data = dest_reg - step;
        end
        else
          dec_bad = 1'b1;
      end
      `DTD_TOP_REG_LOAD:
      begin
        dec_size = op_low[1:0];
        uses_source = 1'b1;
        if (op_low == `DTD_LOW_MOVE)
          dec_rf_we = 1'b1;
        else if (op_low <= `DTD_LOW_PLAIN_L)
        begin
          dec_mem = 1'b1;
          dec_load = 1'b1;
          dec_addr = source_reg;
        end
        else if (op_low >= `DTD_LOW_AUTO_B && op_low <= `DTD_LOW_AUTO_L)
        begin
          dec_mem = 1'b1;
          dec_load = 1'b1;
          dec_addr = source_reg;
          dec_rf_we = 1'b1;
          dec_rf_sel = source_field;
          dec_rf_data = source_reg + step;
        end
        else
          dec_bad = 1'b1;
      end
      default: dec_bad = 1'b1;
    endcase
  end

  // Stall terms; the bus carries one data access at a time
  wire bus_busy = mem_req & ~mem_ack;
  wire contention = dec_mem & fetch_busy;
  wire load_use = mem_req & mem_ack & pend_load &
                  ((uses_dest & (dest_field == pend_dest)) |
                   (uses_source & (source_field == pend_dest)) |
                   (uses_zero & (pend_dest == `DTD_REG_ZERO)));
  assign instr_ready = ~(bus_busy | contention | load_use);
  wire fire = instr_valid & instr_ready;
  wire ld_we = mem_req & mem_ack & pend_load;

  // Register file; a write from the newer instruction beats a landing load
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_reg
      always @(posedge ref_clk)
      begin
        if (sys_rst)
          rf[gi] <= `DTD_REG_RESET;
        else if (fire & dec_rf_we & (dec_rf_sel == gi))
          rf[gi] <= dec_rf_data;
        else if (ld_we & (pend_dest == gi))
          rf[gi] <= load_ext;
      end
    end
  endgenerate

  // Bus request is held until acknowledged; a new one may follow at once
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_size <= `DTD_SZ_BYTE;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
      pend_load <= 1'b0;
      pend_dest <= `DTD_REG_ZERO;
    end
    else if (fire & dec_mem)
    begin
      mem_req <= 1'b1;
      mem_we <= ~dec_load;
      mem_size <= dec_size;
      mem_addr <= dec_addr;
      mem_wdata <= dec_wdata;
      pend_load <= dec_load;
      pend_dest <= dec_ld_dest;
    end
    else if (mem_ack)
    begin
      mem_req <= 1'b0;
      pend_load <= 1'b0;
    end
  end

  // Flag write strobe stays low: transfers never touch the condition flag
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      cpu_flags_we <= 1'b0;
    else
      cpu_flags_we <= 1'b0;
  end

  // Unknown encodings retire as no-ops and pulse a flag for the trap logic
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      illegal_op <= 1'b0;
    else
      illegal_op <= fire & dec_bad;
  end

  // Registered view of one register for inspection
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      peek_data <= `DTD_REG_RESET;
    else
      peek_data <= rf[peek_sel];
  end

endmodule // dtd_transfer_unit

/* dtd_defs.vh */
// Constants for the data-transfer decode and execute unit
`ifndef DTD_DEFS_VH
`define DTD_DEFS_VH

// Top nibble of the instruction word
`define DTD_TOP_IDX_STORE 4'h0
`define DTD_TOP_DISP_STL 4'h1
`define DTD_TOP_REG_STORE 4'h2
`define DTD_TOP_DISP_LDL 4'h5
`define DTD_TOP_REG_LOAD 4'h6
`define DTD_TOP_DISP_R0 4'h8
`define DTD_TOP_PC_LDW 4'h9
`define DTD_TOP_PC_LDL 4'hd
`define DTD_TOP_IMM 4'he

// Low nibble selectors
`define DTD_LOW_PLAIN_B 4'h0
`define DTD_LOW_PLAIN_L 4'h2
`define DTD_LOW_MOVE 4'h3
`define DTD_LOW_AUTO_B 4'h4
`define DTD_LOW_AUTO_W 4'h5
`define DTD_LOW_AUTO_L 4'h6

// Second nibble of the register-zero displacement group
`define DTD_SUB_ST_B 4'h0
`define DTD_SUB_ST_W 4'h1
`define DTD_SUB_LD_B 4'h4
`define DTD_SUB_LD_W 4'h5

// Access size codes
`define DTD_SZ_BYTE 2'h0
`define DTD_SZ_WORD 2'h1
`define DTD_SZ_LONG 2'h2

// Register zero index and reset value of every register
`define DTD_REG_ZERO 4'h0
`define DTD_REG_RESET 32'h00000000

`endif

/* dtd_load_extend.v */
// Sign extension of byte, word and longword data to 32 bits
`timescale 1ns/1ps
`include "dtd_defs.vh"

module dtd_load_extend (
  input wire [1:0] size,
  input wire [31:0] raw,
  output reg [31:0] ext
);

  // Longwords pass unchanged, narrower data copies its top bit upward
  always @*
  begin
    case (size)
      `DTD_SZ_BYTE: ext = {{24{raw[7]}}, raw[7:0]};
      `DTD_SZ_WORD: ext = {{16{raw[15]}}, raw[15:0]};
      default: ext = raw;
    endcase
  end

endmodule // dtd_load_extend

/* dtd_transfer_sva.sv */
// Port assertions for the data-transfer unit
`timescale 1ns/1ps
module dtd_transfer_sva (
  input wire ref_clk,
  input wire sys_rst,
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire [31:0] program_counter,
  input wire instr_ready,
  input wire fetch_busy,
  input wire mem_req,
  input wire mem_we,
  input wire [1:0] mem_size,
  input wire [31:0] mem_addr,
  input wire mem_ack,
  input wire cpu_flags_we
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // Accepted instruction and its top nibble
  wire take = instr_valid && instr_ready;
  wire [3:0] top = instr_word[15:12];
  // Transfers never touch the flag
  property p_flag_kept;
    cpu_flags_we == 1'h0;
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("flag written");
  // A pending access holds back every instruction
  property p_pend_stall;
    mem_req && !mem_ack |-> !instr_ready;
  endproperty
  a_pend_stall: assert property (p_pend_stall) else $error("taken while busy");
  // Request stays steady until acknowledged
  property p_req_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_size);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved");
  // A program-counter longword load yields to an instruction fetch
  property p_fetch_stall;
    instr_valid && fetch_busy && top == 4'hd |-> !instr_ready;
  endproperty
  a_fetch_stall: assert property (p_fetch_stall) else $error("fetch clash");
  // Longword load relative to the program counter
  property p_pc_long;
    take && top == 4'hd |=> mem_req && !mem_we && mem_size == 2'h2
      && mem_addr == $past(program_counter) + {22'h0, $past(instr_word[7:0]), 2'h0};
  endproperty
  a_pc_long: assert property (p_pc_long) else $error("pc long access");
  // Word load relative to the program counter
  property p_pc_word;
    take && top == 4'h9 |=> mem_req && !mem_we && mem_size == 2'h1
      && mem_addr == $past(program_counter) + {23'h0, $past(instr_word[7:0]), 1'h0};
  endproperty
  a_pc_word: assert property (p_pc_word) else $error("pc word access");
  // Register-only transfers leave the bus alone
  property p_no_access;
    take && (top == 4'he || top == 4'h6 && instr_word[3:0] == 4'h3) |=> !mem_req;
  endproperty
  a_no_access: assert property (p_no_access) else $error("stray access");
  // With the bus free an instruction goes in at once
  property p_idle_ready;
    instr_valid && !mem_req && !fetch_busy |-> instr_ready;
  endproperty
  a_idle_ready: assert property (p_idle_ready) else $error("needless stall");
endmodule // dtd_transfer_sva

/* dtd_transfer_unit_tb.sv */
// Random and directed bench for the data-transfer unit
`timescale 1ns/1ps
module dtd_transfer_unit_tb;
  localparam [39:0] forms = 40'he9d6215803;
  localparam [223:0] hand = {16'h6ce0, 16'h3fff, 16'hdd7f, 16'h9f80, 16'h5cdf, 16'h1abf,
    16'h0454, 16'h8475, 16'h8155, 16'h2365, 16'h2164, 16'h6334, 16'h6653, 16'h6512};
  reg ref_clk, sys_rst, instr_valid, fetch_busy, mem_ack, bad;
  reg [15:0] instr_word;
  reg [31:0] program_counter, mem_rdata, lf, cyc;
  reg [31:0] rf [0:15];
  reg [3:0] peek_sel;
  reg [66:0] q [$];
  integer n_fail, tests_run, i, s;
  wire instr_ready, mem_req, mem_we, cpu_flags_we, illegal_op;
  wire [1:0] mem_size;
  wire [31:0] mem_addr, mem_wdata, peek_data;
  dtd_transfer_unit dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .program_counter(program_counter), .instr_ready(instr_ready),
    .fetch_busy(fetch_busy), .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .cpu_flags_we(cpu_flags_we), .illegal_op(illegal_op), .peek_sel(peek_sel),
    .peek_data(peek_data));
  // Pseudo-random source, memory contents and load extension
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function [31:0] rd(input [31:0] a);
    rd = a * 32'h9e3779b1;
  endfunction
  function [31:0] ext(input [1:0] z, input [31:0] v);
    ext = z == 2'h0 ? {{24{v[7]}}, v[7:0]} : z == 2'h1 ? {{16{v[15]}}, v[15:0]} : v;
  endfunction
  // Random transfer, or illegal top nibble 3; pre-decrement keeps source apart from address register
  function [15:0] pick(input [31:0] r);
    reg [3:0] t, n, m, lo;
    begin
      t = forms[(r[31:24] % 10) * 4 +: 4];
      {n, m, lo} = r[11:0];
      if (t == 4'h6 || t == 4'h2) lo = {1'h0, r[2], r[1:0] == 2'h3 ? 2'h2 : r[1:0]};
      if (t == 4'h6 && r[12]) lo = 4'h3;
      if (t == 4'h2 && lo[2]) m = n ^ 4'h1;
      if (t == 4'h0) lo = {3'h2, r[0]};
      if (t == 4'h8) n = {1'h0, r[13], 1'h0, r[12]};
      pick = {t, n, m, lo};
    end
  endfunction
  // Automatic: the memory process and the instruction process may compare in one step
  task automatic check(input [79:0] what, input [66:0] got, input [66:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("unexpected %0s: expected %h, seen %h", what, exp, got);
      end
    end
  endtask
  // Expected effect of one instruction on registers and the bus
  task model(input [15:0] w);
    reg [3:0] t, n, m, lo, dn;
    reg [1:0] z;
    reg [31:0] pa, d;
    reg ld, st, dec, inc;
    begin
      {t, n, m, lo} = w;
      bad = 1'h0;
      {ld, st, dec, inc, dn, z, d} = {4'h0, n, lo[1:0], rf[m]};
      case (t)
        4'he: rf[n] = {{24{w[7]}}, w[7:0]};
        4'hd: {ld, z, pa} = {3'h6, program_counter + {w[7:0], 2'h0}};
        4'h9: {ld, z, pa} = {3'h5, program_counter + {w[7:0], 1'h0}};
        4'h6: if (lo == 4'h3) rf[n] = rf[m];
          else {ld, inc, pa} = {1'h1, lo[2], rf[m]};
        4'h2: {st, dec, pa} = {1'h1, lo[2], rf[n]};
        4'h1: {st, z, pa} = {3'h6, rf[n] + {lo, 2'h0}};
        4'h5: {ld, z, pa} = {3'h6, rf[m] + {lo, 2'h0}};
        4'h8: {ld, st, z, dn, pa, d} = {n[2], !n[2], 1'h0, n[0], 4'h0,
          rf[m] + ({28'h0, lo} << n[0]), rf[0]};
        4'h0: {st, pa} = {1'h1, rf[0] + rf[n]};
        default: bad = 1'h1;
      endcase
      if (dec) rf[n] = rf[n] - (32'h1 << z);
      if (dec) pa = rf[n];
      if (ld || st) q.push_back({st, z, pa, st ? d : 32'h0});
      if (inc) rf[m] = rf[m] + (32'h1 << z);
      if (ld) rf[dn] = ext(z, rd(pa));
    end
  endtask
  // Present one instruction and hold it until taken
  task issue(input [15:0] w);
    begin
      instr_valid = 1'h1;
      instr_word = w;
      program_counter = lf;
      lf = nx(lf);
      model(w);
      #1;
      while (instr_ready !== 1'h1) @(negedge ref_clk) #1;
      @(negedge ref_clk);
      // Unknown codes retire as no-ops and pulse the flag in the cycle after
      check("illegal", illegal_op, bad);
    end
  endtask
  // Let the bus drain, then read back every register
  task chk_regs(input [79:0] nm);
    begin
      instr_valid = 1'h0;
      while (mem_req !== 1'h0) @(negedge ref_clk);
      check("queue", q.size(), 67'h0);
      for (i = 0; i < 16; i = i + 1)
      begin
        peek_sel = i[3:0];
        @(negedge ref_clk);
        check("register", peek_data, rf[i]);
      end
      $display("%0s test done, %0d checks", nm, tests_run);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial
  begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Memory with random wait states; fetches steal the bus at random
  always @(negedge ref_clk)
  begin
    mem_ack = 1'h0;
    mem_rdata = ~mem_rdata;
    if (mem_req === 1'h1 && lf[3])
    begin
      mem_ack = 1'h1;
      mem_rdata = rd(mem_addr);
      check("access", {mem_we, mem_size, mem_addr, mem_we ? mem_wdata : 32'h0},
        q.pop_front());
    end
    fetch_busy = lf[9];
    lf = nx(lf);
  end
  // Cycle count with a ceiling far above the expected run
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      cyc <= 32'h0;
    else
      cyc <= cyc + 32'h1;
    if (cyc == 32'h4e20)
    begin
      n_fail = n_fail + 1;
      test_done;
    end
  end
  initial
  begin
    {sys_rst, instr_valid, fetch_busy, mem_ack, instr_word, peek_sel} = 24'h800000;
    {program_counter, mem_rdata} = 64'h0;
    {n_fail, tests_run} = 64'h0;
    lf = 32'hc2e727c5;
    for (i = 0; i < 16; i = i + 1)
      rf[i] = 32'h0;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'h0;
    chk_regs("reset");
    s = cyc;
    for (i = 0; i < 16; i = i + 1)
      issue({4'he, i[3:0], lf[15:8]});
    check("cycles", cyc - s, 67'h10);
    chk_regs("immediate");
    for (i = 0; i < 14; i = i + 1)
      issue(hand[i * 16 +: 16]);
    chk_regs("directed");
    for (i = 0; i < 400; i = i + 1)
      issue(pick(lf));
    chk_regs("random");
    test_done;
  end
endmodule // dtd_transfer_unit_tb
bind dtd_transfer_unit dtd_transfer_sva sva_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .instr_valid(instr_valid), .instr_word(instr_word), .program_counter(program_counter),
  .instr_ready(instr_ready), .fetch_busy(fetch_busy), .mem_req(mem_req), .mem_we(mem_we),
  .mem_size(mem_size), .mem_addr(mem_addr), .mem_ack(mem_ack), .cpu_flags_we(cpu_flags_we));
